// >>> pkg/ulsm_pkg.sv
// package: constants and types for the serial mode and termination logic
package ulsm_pkg;
    // ---------------------------------------------------------------
    // bus bit positions
    // ---------------------------------------------------------------
    localparam int BIT_TX_EN = 0;
    localparam int BIT_TX_DATA = 1;
    localparam int BIT_TX_ZERO = 2;
    localparam int BIT_INT = 3;
    localparam int BIT_RX_POS = 4;
    localparam int BIT_RX_NEG = 5;
    localparam int BIT_RX_DIFF = 6;
    localparam int BIT_RSVD7 = 7;
    // ---------------------------------------------------------------
    // field encodings
    // ---------------------------------------------------------------
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [1:0] OPM_NON_DRIVING = 2'h1;
    localparam logic [1:0] OPM_CHIRP = 2'h2;
    localparam logic [1:0] XCVR_HS = 2'h0;
    localparam logic [7:0] BUS_IDLE = 8'h00;
    // ---------------------------------------------------------------
    // host command port offsets and field positions
    // ---------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_XCVR = 4'h4;
    localparam logic [3:0] ADDR_TX = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;
    localparam int CTRL_SIX = 0;
    localparam int CTRL_THREE = 1;
    localparam int CTRL_KEEP = 2;
    localparam int CTRL_STOP = 3;
    localparam int XCVR_SEL_LSB = 0;
    localparam int XCVR_TERM = 2;
    localparam int XCVR_OPM_LSB = 3;
    localparam int XCVR_DPPD = 5;
    localparam int XCVR_DMPD = 6;
    localparam logic [7:0] XCVR_RESET = 8'h61;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        ULSM_SYNC = 3'b001,
        ULSM_SIX = 3'b010,
        ULSM_THREE = 3'b100
    } ulsm_mode_type;

    typedef struct packed {
        logic pos_pullup_enable;
        logic pos_pulldown_enable;
        logic neg_pulldown_enable;
        logic hs_termination_enable;
    } ulsm_res_type;
endpackage : ulsm_pkg

// >>> pkg/ulsm_if.sv
// interface: the link-side data bus, stop and direction between both ends
interface ulsm_if;
    logic [7:0] phy_data;
    logic [7:0] phy_oe;
    logic [7:0] link_data;
    logic [7:0] link_oe;
    logic stop;
    logic dir;
    logic clk_run;

    modport phy (input link_data, input link_oe, input stop,
        output phy_data, output phy_oe, output dir, output clk_run);
    modport link (input phy_data, input phy_oe, input dir, input clk_run,
        output link_data, output link_oe, output stop);
endinterface : ulsm_if

// >>> core/ulsm_term_decode.sv
// module: combinational resistor enable derivation from line state fields
module ulsm_term_decode
    import ulsm_pkg::*;
(
    input wire logic [1:0] i_transceiver_select,
    input wire logic i_termination_select,
    input wire logic [1:0] i_operating_mode,
    input wire logic i_pos_line_pulldown_field,
    input wire logic i_neg_line_pulldown_field,
    output ulsm_res_type o_res
);
    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    always_comb begin
        o_res = '0;
        if (i_operating_mode != OPM_NON_DRIVING) begin
            o_res.pos_pulldown_enable = i_pos_line_pulldown_field;
            o_res.neg_pulldown_enable = i_neg_line_pulldown_field;
            // host rows never pull up; peripheral pull-up on fs/ls termination
            o_res.pos_pullup_enable = i_termination_select &
                ~(i_pos_line_pulldown_field & i_neg_line_pulldown_field);
            // termination only when hs transceiver with termination select low
            o_res.hs_termination_enable = (i_transceiver_select == XCVR_HS) &
                ~i_termination_select;
        end
    end
endmodule : ulsm_term_decode

// >>> core/ulsm_phy_end.sv
// module: transceiver end of the serial mode bus and line resistor control
//
// Overview of operation
// - Six-pin enable bit set remaps bus
// - Stop exits six-pin mode to synchronous
// - Keep-alive bit keeps clock during serial
// - Link drives enable bit 0; data, SE0 bits 1-2 only while enable is set
// - Device drives receive_pos_line, dm, rcv bits 4-6
// - Bit 3 carries unmasked interrupt, active high
// - Six-pin bit 7 held low
// - Three-pin enable bit set remaps bus
// - Stop exits three-pin mode to synchronous
// - Bit 1 direction follows transmit enable
// - Bit 2 direction follows transmit enable
// - Three-pin bits 7:4 held low
// - Interrupt line present in each serial mode
// - Line state from five register fields
// - Link alone chooses field combination
// - Four resistor enables driven
// - Non-driving mode clears all enables
// - Host: pulldowns on, pullup off, hs term selective
// - Host suspend/resume: only pulldowns
// - Host ls suspend/resume: only pulldowns
// - Link holds stop high to exit
//
// The plain strobed port and the register offsets were chosen for this implementation.
module ulsm_phy_end
    import ulsm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    ulsm_if.phy bus,
    input wire logic i_six_wire_serial_enable,
    input wire logic i_three_wire_serial_enable,
    input wire logic i_clock_keep_alive,
    input wire logic [1:0] i_transceiver_select,
    input wire logic i_termination_select,
    input wire logic [1:0] i_operating_mode,
    input wire logic i_pos_line_pulldown_field,
    input wire logic i_neg_line_pulldown_field,
    input wire logic i_irq_pending,
    input wire logic i_receive_pos_line,
    input wire logic i_receive_neg_line,
    input wire logic i_receive_differential,
    input wire logic i_receive_se0,
    output ulsm_mode_type o_mode,
    output logic o_tx_enable,
    output logic o_transmit_diff_in,
    output logic o_transmit_single_ended_zero_in,
    output logic o_pos_pullup_enable,
    output logic o_pos_pulldown_enable,
    output logic o_neg_pulldown_enable,
    output logic o_hs_termination_enable
);
    ulsm_mode_type mode_reg;
    ulsm_res_type res;
    logic tx_en;

    assign tx_en = bus.link_data[BIT_TX_EN];
    assign o_mode = mode_reg;

    // ---------------------------------------------------------------
    // bus maps
    // ---------------------------------------------------------------
    function automatic logic in_serial(input ulsm_mode_type m);
        return (m == ULSM_SIX) || (m == ULSM_THREE);
    endfunction : in_serial

    function automatic logic [7:0] six_word(input logic irq, input logic pos,
        input logic neg, input logic diff);
        logic [7:0] w;
        w = BUS_IDLE;
        w[BIT_INT] = irq;
        w[BIT_RX_POS] = pos;
        w[BIT_RX_NEG] = neg;
        w[BIT_RX_DIFF] = diff;
        w[BIT_RSVD7] = 1'b0;
        return w;
    endfunction : six_word

    // bits 1-2 carry receive data only while transmit enable is low
    function automatic logic [7:0] three_word(input logic irq, input logic txe,
        input logic diff, input logic se0);
        logic [7:0] w;
        w = BUS_IDLE;
        w[BIT_TX_DATA] = ~txe & diff;
        w[BIT_TX_ZERO] = ~txe & se0;
        w[BIT_INT] = irq;
        return w;
    endfunction : three_word

    // transmit bits only count while transmit enable is high
    function automatic logic [2:0] tx_capture(input logic [7:0] d);
        logic [2:0] c;
        c[0] = d[BIT_TX_EN];
        c[1] = d[BIT_TX_EN] & d[BIT_TX_DATA];
        c[2] = d[BIT_TX_EN] & d[BIT_TX_ZERO];
        return c;
    endfunction : tx_capture

    // ---------------------------------------------------------------
    // mode control
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_reg <= ULSM_SYNC;
        end else begin
            case (mode_reg)
                ULSM_SYNC: begin
                    if (i_six_wire_serial_enable) begin
                        mode_reg <= ULSM_SIX;
                    end else if (i_three_wire_serial_enable) begin
                        mode_reg <= ULSM_THREE;
                    end
                end
                ULSM_SIX: begin
                    if (bus.stop) begin
                        mode_reg <= ULSM_SYNC;
                    end
                end
                ULSM_THREE: begin
                    if (bus.stop) begin
                        mode_reg <= ULSM_SYNC;
                    end
                end
                default: begin
                    mode_reg <= ULSM_SYNC;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // bus drive
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.phy_data <= BUS_IDLE;
            bus.phy_oe <= BUS_IDLE;
            bus.dir <= 1'b0;
        end else begin
            bus.phy_data <= BUS_IDLE;
            bus.phy_oe <= BUS_IDLE;
            bus.dir <= 1'b0;
            case (mode_reg)
                ULSM_SIX: begin
                    bus.dir <= 1'b1;
                    bus.phy_oe <= 8'hF8;
                    bus.phy_data <= six_word(i_irq_pending, i_receive_pos_line,
                        i_receive_neg_line, i_receive_differential);
                end
                ULSM_THREE: begin
                    bus.dir <= 1'b1;
                    // rx bits turn around with transmit enable
                    bus.phy_oe <= tx_en ? 8'hF8 : 8'hFE;
                    bus.phy_data <= three_word(i_irq_pending, tx_en, i_receive_differential,
                        i_receive_se0);
                end
                default: begin
                    bus.dir <= 1'b0;
                end
            endcase
        end
    end

    // clock may stop in serial modes unless kept alive
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.clk_run <= 1'b1;
        end else begin
            bus.clk_run <= !in_serial(mode_reg) || i_clock_keep_alive;
        end
    end

    // ---------------------------------------------------------------
    // link transmit capture
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_enable <= 1'b0;
            o_transmit_diff_in <= 1'b0;
            o_transmit_single_ended_zero_in <= 1'b0;
        end else if (!in_serial(mode_reg)) begin
            o_tx_enable <= 1'b0;
            o_transmit_diff_in <= 1'b0;
            o_transmit_single_ended_zero_in <= 1'b0;
        end else begin
            {o_transmit_single_ended_zero_in, o_transmit_diff_in, o_tx_enable} <=
                tx_capture(bus.link_data);
        end
    end

    // ---------------------------------------------------------------
    // resistor enables
    // ---------------------------------------------------------------
    ulsm_term_decode u_decode (
        .i_transceiver_select(i_transceiver_select),
        .i_termination_select(i_termination_select),
        .i_operating_mode(i_operating_mode),
        .i_pos_line_pulldown_field(i_pos_line_pulldown_field),
        .i_neg_line_pulldown_field(i_neg_line_pulldown_field),
        .o_res(res)
    );

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pos_pullup_enable <= 1'b0;
            o_pos_pulldown_enable <= 1'b0;
            o_neg_pulldown_enable <= 1'b0;
            o_hs_termination_enable <= 1'b0;
        end else begin
            o_pos_pullup_enable <= res.pos_pullup_enable;
            o_pos_pulldown_enable <= res.pos_pulldown_enable;
            o_neg_pulldown_enable <= res.neg_pulldown_enable;
            o_hs_termination_enable <= res.hs_termination_enable;
        end
    end
endmodule : ulsm_phy_end

// >>> core/ulsm_link_end.sv
// module: link controller end, command registers and serial line drive
module ulsm_link_end
    import ulsm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    ulsm_if.link bus,
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_six_wire_serial_enable,
    output logic o_three_wire_serial_enable,
    output logic o_clock_keep_alive,
    output logic [1:0] o_transceiver_select,
    output logic o_termination_select,
    output logic [1:0] o_operating_mode,
    output logic o_pos_line_pulldown_field,
    output logic o_neg_line_pulldown_field
);
    logic [2:0] tx_reg;
    logic [7:0] xcvr_reg;
    logic stop_reg;
    logic [7:0] status;

    // ---------------------------------------------------------------
    // command registers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_six_wire_serial_enable <= 1'b0;
            o_three_wire_serial_enable <= 1'b0;
            o_clock_keep_alive <= 1'b0;
            stop_reg <= 1'b0;
        end else begin
            // enables self-clear once the device takes the bus
            if (bus.dir) begin
                o_six_wire_serial_enable <= 1'b0;
                o_three_wire_serial_enable <= 1'b0;
            end
            // stop held until the device releases the bus
            if (stop_reg && !bus.dir) begin
                stop_reg <= 1'b0;
            end
            if (i_wr && i_addr == ADDR_CTRL) begin
                o_six_wire_serial_enable <= i_wdata[CTRL_SIX];
                o_three_wire_serial_enable <= i_wdata[CTRL_THREE] & ~i_wdata[CTRL_SIX];
                o_clock_keep_alive <= i_wdata[CTRL_KEEP];
                if (i_wdata[CTRL_STOP]) begin
                    stop_reg <= 1'b1;
                end
            end
        end
    end

    // field combination chosen here only
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            xcvr_reg <= XCVR_RESET;
        end else if (i_wr && i_addr == ADDR_XCVR) begin
            xcvr_reg <= i_wdata[7:0];
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_reg <= 3'h0;
        end else if (i_wr && i_addr == ADDR_TX) begin
            tx_reg <= i_wdata[2:0];
        end
    end

    assign o_transceiver_select = xcvr_reg[XCVR_SEL_LSB +: 2];
    assign o_termination_select = xcvr_reg[XCVR_TERM];
    assign o_operating_mode = xcvr_reg[XCVR_OPM_LSB +: 2];
    assign o_pos_line_pulldown_field = xcvr_reg[XCVR_DPPD];
    assign o_neg_line_pulldown_field = xcvr_reg[XCVR_DMPD];

    // ---------------------------------------------------------------
    // link bus drive
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus.link_data <= BUS_IDLE;
            bus.link_oe <= BUS_IDLE;
            bus.stop <= 1'b0;
        end else begin
            bus.stop <= stop_reg;
            bus.link_data <= {5'h00, tx_reg};
            // tx bits 1-2 driven only once the device has released them
            bus.link_oe <= (tx_reg[0] && !bus.phy_oe[BIT_TX_DATA]) ? 8'h07 : 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // status read
    // ---------------------------------------------------------------
    assign status = {bus.phy_data[7:3], bus.clk_run, stop_reg, bus.dir};

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= RDATA_ZERO;
        end else if (i_rd) begin
            case (i_addr)
                ADDR_CTRL: o_rdata <= {28'h0000000, stop_reg, o_clock_keep_alive,
                    o_three_wire_serial_enable, o_six_wire_serial_enable};
                ADDR_XCVR: o_rdata <= {24'h000000, xcvr_reg};
                ADDR_TX: o_rdata <= {29'h0000000, tx_reg};
                ADDR_STATUS: o_rdata <= {24'h000000, status};
                default: o_rdata <= RDATA_ZERO;
            endcase
        end else begin
            o_rdata <= RDATA_ZERO;
        end
    end
endmodule : ulsm_link_end

// >>> testbench/ulsm_chk.sv
// checker: assertions on the bus between the link end and the transceiver end
module ulsm_chk (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic [7:0] phy_data,
    input wire logic [7:0] phy_oe,
    input wire logic [7:0] link_data,
    input wire logic [7:0] link_oe,
    input wire logic stop,
    input wire logic dir,
    input wire logic clk_run
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    // ---------------------------------------------------------------
    // serial mode steps
    // ---------------------------------------------------------------
    sequence serial_held;
        dir && !stop;
    endsequence
    sequence stop_seen;
        dir && stop;
    endsequence

    bit7_low_a: assert property (dir |-> !phy_data[7])
        else $error("reserved bit 7 driven high");
    upper_low_a: assert property (dir && phy_oe == 8'hFE |-> phy_data[7:4] == 4'h0)
        else $error("upper bits not low in three wire mode");
    oe_shape_a: assert property (dir |-> phy_oe == 8'hF8 || phy_oe == 8'hFE)
        else $error("device enables do not match a serial map");
    sync_release_a: assert property (!dir |-> phy_oe == 8'h00)
        else $error("device drives bus in synchronous mode");
    stop_exit_a: assert property (stop_seen |-> ##[1:4] !dir)
        else $error("stop did not end serial mode");
    mode_hold_a: assert property (serial_held |=> dir)
        else $error("serial mode left without stop");
    no_contend_a: assert property ((phy_oe & link_oe) == 8'h00)
        else $error("both ends drive the same bit");
    clk_keep_a: assert property (!dir |-> clk_run)
        else $error("clock stopped outside serial mode");
endmodule : ulsm_chk

// >>> testbench/tb_ulpi_serial_mode_and_termination_ctrl.sv
// testbench: both ends joined, register port stimulus and bus checks
module tb_ulpi_serial_mode_and_termination_ctrl
    import ulsm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic irq = 1'b0;
    logic rx_pos = 1'b0;
    logic rx_neg = 1'b0;
    logic rx_diff = 1'b0;
    logic rx_zero = 1'b0;
    logic six, three, keep, term, dppd, dmpd;
    logic [1:0] sel, opm;
    ulsm_mode_type mode;
    logic tx_en, tx_data, tx_zero, pu, pdp, pdm, hst;
    logic [2:0] pat3;
    int num_errors = 0;
    int checks_done = 0;
    // {expected pu,pdp,pdm,hst, field word}
    localparam logic [11:0] TERM_TAB [12] = '{12'h068, 12'h00D, 12'h770, 12'h760, 12'h665,
        12'h667, 12'h675, 12'h666, 12'h676, 12'h661, 12'h805, 12'h100};

    ulsm_if bus ();
    ulsm_link_end i_ulsm_link_end (.i_clk_sys(clk), .i_rst_n(rst_n), .bus(bus.link),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_six_wire_serial_enable(six), .o_three_wire_serial_enable(three),
        .o_clock_keep_alive(keep), .o_transceiver_select(sel), .o_termination_select(term),
        .o_operating_mode(opm), .o_pos_line_pulldown_field(dppd),
        .o_neg_line_pulldown_field(dmpd));
    ulsm_phy_end i_ulsm_phy_end (.i_clk_sys(clk), .i_rst_n(rst_n), .bus(bus.phy),
        .i_six_wire_serial_enable(six), .i_three_wire_serial_enable(three),
        .i_clock_keep_alive(keep), .i_transceiver_select(sel), .i_termination_select(term),
        .i_operating_mode(opm), .i_pos_line_pulldown_field(dppd),
        .i_neg_line_pulldown_field(dmpd), .i_irq_pending(irq), .i_receive_pos_line(rx_pos),
        .i_receive_neg_line(rx_neg), .i_receive_differential(rx_diff), .i_receive_se0(rx_zero),
        .o_mode(mode), .o_tx_enable(tx_en), .o_transmit_diff_in(tx_data),
        .o_transmit_single_ended_zero_in(tx_zero), .o_pos_pullup_enable(pu),
        .o_pos_pulldown_enable(pdp), .o_neg_pulldown_enable(pdm),
        .o_hs_termination_enable(hst));
    ulsm_chk i_ulsm_chk (.i_clk_sys(clk), .i_rst_n(rst_n), .phy_data(bus.phy_data),
        .phy_oe(bus.phy_oe), .link_data(bus.link_data), .link_oe(bus.link_oe),
        .stop(bus.stop), .dir(bus.dir), .clk_run(bus.clk_run));

    // ---------------------------------------------------------------
    // clock, access tasks and report
    // ---------------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string nm);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask : rd_chk

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask : settle

    task automatic wait_dir(input logic v);
        int n;
        n = 0;
        while (bus.dir !== v && n < 20) begin
            @(posedge clk);
            n++;
        end
        #1;
        chk("dir", {31'h0, v}, {31'h0, bus.dir});
    endtask : wait_dir

    task automatic chk_mode(input ulsm_mode_type m, input logic [7:0] oe);
        settle();
        chk("mode", {29'h0, m}, {29'h0, mode});
        chk("phy_oe", {24'h0, oe}, {24'h0, bus.phy_oe});
    endtask : chk_mode

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        final_report();
    end

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        rd_chk(ADDR_XCVR, {24'h0, XCVR_RESET}, "xcvr reset");
        chk("res reset", 32'h6, {28'h0, pu, pdp, pdm, hst});
        rd_chk(ADDR_STATUS, 32'h4, "status reset");
        rd_chk(4'h2, 32'h0, "unmapped");
        for (int i = 0; i < 12; i++) begin
            wr_reg(ADDR_XCVR, {24'h0, TERM_TAB[i][7:0]});
            rd_chk(ADDR_XCVR, {24'h0, TERM_TAB[i][7:0]}, "xcvr readback");
            settle();
            chk("res", {28'h0, TERM_TAB[i][11:8]}, {28'h0, pu, pdp, pdm, hst});
        end
        // six wire with clock kept alive
        wr_reg(ADDR_CTRL, 32'h5);
        wait_dir(1'b1);
        chk_mode(ULSM_SIX, 8'hF8);
        chk("clk_run", 32'h1, {31'h0, bus.clk_run});
        rd_chk(ADDR_CTRL, 32'h4, "ctrl keep");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {rx_diff, rx_neg, rx_pos, irq} <= 4'(i * 5);
            settle();
            chk("six rx", {24'h0, 1'b0, 4'(i * 5), 3'h0}, {24'h0, bus.phy_data & 8'hF8});
        end
        rd_chk(ADDR_STATUS, 32'h7D, "status six");
        for (int i = 0; i < 3; i++) begin
            pat3 = (i == 0) ? 3'h3 : ((i == 1) ? 3'h5 : 3'h0);
            wr_reg(ADDR_TX, {29'h0, pat3});
            rd_chk(ADDR_TX, {29'h0, pat3}, "tx readback");
            settle();
            chk("six tx", {29'h0, pat3[0], pat3[1], pat3[2]}, {29'h0, tx_en, tx_data, tx_zero});
        end
        wr_reg(ADDR_CTRL, 32'h8);
        wait_dir(1'b0);
        chk_mode(ULSM_SYNC, 8'h00);
        // three wire, receive direction then transmit direction
        wr_reg(ADDR_CTRL, 32'h2);
        wait_dir(1'b1);
        chk_mode(ULSM_THREE, 8'hFE);
        chk("clk_run off", 32'h0, {31'h0, bus.clk_run});
        for (int j = 0; j < 2; j++) begin
            pat3 = (j == 0) ? 3'h7 : 3'h2;
            @(posedge clk);
            rx_diff <= pat3[0];
            rx_zero <= pat3[1];
            irq <= pat3[2];
            settle();
            chk("three rx", {24'h0, 4'h0, pat3, 1'b0}, {24'h0, bus.phy_data & 8'hFE});
        end
        wr_reg(ADDR_TX, 32'h7);
        chk_mode(ULSM_THREE, 8'hF8);
        chk("three tx", 32'h7, {29'h0, tx_en, tx_data, tx_zero});
        wr_reg(ADDR_TX, 32'h0);
        chk_mode(ULSM_THREE, 8'hFE);
        wr_reg(ADDR_CTRL, 32'h8);
        wait_dir(1'b0);
        chk_mode(ULSM_SYNC, 8'h00);
        // stop in sync is ignored, both enables pick six wire
        wr_reg(ADDR_CTRL, 32'h8);
        chk_mode(ULSM_SYNC, 8'h00);
        wr_reg(ADDR_CTRL, 32'h3);
        wait_dir(1'b1);
        chk_mode(ULSM_SIX, 8'hF8);
        wr_reg(ADDR_CTRL, 32'h8);
        wait_dir(1'b0);
        final_report();
    end
endmodule : tb_ulpi_serial_mode_and_termination_ctrl
